// ===== inc/ccoc_pkg.sv
package ccoc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SENSE_W = 16;
  localparam int VOLT_W  = 16;
  localparam int CAP_W   = 16;
  localparam int TEMP_W  = 12;
  localparam int DB_W    = 8;
  localparam int REG_W   = 8;
  localparam int NUM_W   = 32;
  localparam int DEN_W   = 24;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int AVG_WIN_MS    = 5120;
  localparam int QUICK_MS      = 1280;
  localparam int FULL_DLY_S    = 40;
  localparam int CAL_PERIOD_S  = 60;
  localparam int SD_PERIOD_S   = 3600;
  localparam int SLEEP_MS      = 20;
  localparam int AVG_TICKS     = AVG_WIN_MS / TICK_MS;
  localparam int QUICK_TICKS   = QUICK_MS / TICK_MS;
  localparam int FULL_DLY_TICKS = (FULL_DLY_S * 1000 + TICK_MS - 1) / TICK_MS;
  localparam int CAL_PER_TICKS = CAL_PERIOD_S * 1000 / TICK_MS;
  localparam int SD_TICKS      = SD_PERIOD_S * 1000 / TICK_MS;
  localparam int SLEEP_TICKS   = (SLEEP_MS + TICK_MS - 1) / TICK_MS;
  localparam int AVG_SHIFT     = $clog2(AVG_TICKS);
  localparam int QUICK_SHIFT   = $clog2(QUICK_TICKS);

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  localparam int    SENSE_LSB_NV     = 4900;
  localparam int    DEADBAND_STEP_NV = 4900;
  localparam int    CAP_UNIT_NVH     = 3570;
  localparam longint CAP_UNIT_L      = longint'(CAP_UNIT_NVH) * 3600 * 1000 / (SENSE_LSB_NV * TICK_MS);
  localparam int    CAP_UNIT_CNT     = int'(CAP_UNIT_L);
  localparam int    TTE_NUM_K        = CAP_UNIT_NVH * 60 / 100;
  localparam int    TTE_DEN_K        = SENSE_LSB_NV / 100;
  localparam int    EDV1_SHIFT       = 4;
  localparam int    COLD_SHIFT       = 3;
  localparam int    SD_SHIFT         = 9;
  localparam int    SD_HOT_SHIFT     = 8;
  localparam logic [TEMP_W-1:0] TEMP_COLD = 12'h445;
  localparam logic [TEMP_W-1:0] TEMP_HOT  = 12'h4f9;

  // ----------------------------------------------------------------
  // Host register
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] CTRL_ADDR  = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST   = 8'h00;
  localparam int               CTRL_QUICK = 0;

  typedef enum logic [1:0] {
    CAL_SETTLE = 2'b00,
    CAL_QUICK  = 2'b01,
    CAL_IDLE   = 2'b10,
    CAL_FULL   = 2'b11
  } ccoc_cal_t;

  typedef struct packed {
    logic signed [SENSE_W-1:0] standby;
    logic signed [SENSE_W-1:0] peak;
    logic signed [SENSE_W-1:0] at_rate;
  } ccoc_loads_t;

  typedef struct packed {
    logic [CAP_W-1:0] standby;
    logic [CAP_W-1:0] peak;
    logic [CAP_W-1:0] actual;
    logic [CAP_W-1:0] at_rate;
  } ccoc_tte_t;

endpackage

// ===== core/ccoc_div.sv
`timescale 1ns/1ps
module ccoc_div
  import ccoc_pkg::*;
#(
  parameter int NW = NUM_W,
  parameter int DW = DEN_W
)(
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic [NW-1:0] num_i,
  input  wire logic [DW-1:0] den_i,
  output logic               done_o,
  output logic [NW-1:0]      quo_o
);

  // A zero divisor yields an all-ones quotient, which the caller
  // reads as "no discharge, time unbounded".
  logic [DW:0]          rem_r, rem_nxt;
  logic [NW-1:0]        q_r, q_nxt;
  logic [DW-1:0]        den_r, den_nxt;
  logic [$clog2(NW):0]  cnt_r, cnt_nxt;
  logic                 busy_r, busy_nxt;
  logic                 done_r, done_nxt;

  always_comb
  begin
    logic [DW:0] sh;
    sh       = '0;
    rem_nxt  = rem_r;
    q_nxt    = q_r;
    den_nxt  = den_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start_i && !busy_r)
    begin
      rem_nxt  = '0;
      q_nxt    = num_i;
      den_nxt  = den_i;
      cnt_nxt  = '0;
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      sh    = {rem_r[DW-1:0], q_r[NW-1]};
      q_nxt = {q_r[NW-2:0], 1'b0};
      if (sh >= {1'b0, den_r})
      begin
        sh       = sh - {1'b0, den_r};
        q_nxt[0] = 1'b1;
      end
      rem_nxt = sh;
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_r == ($clog2(NW)+1)'(NW - 1))
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      rem_r  <= '0;
      q_r    <= '0;
      den_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      rem_r  <= rem_nxt;
      q_r    <= q_nxt;
      den_r  <= den_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign quo_o  = q_r;

endmodule

// ===== core/ccoc_gauge.sv
// What this block does
// - Integrate corrected sense voltage every tick into the charge accumulator.
// - Reported current is the mean sense voltage over a 5.12 s window.
// - Repeat full offset calibration periodically.
// - Calibration-active flag is high exactly while a calibration runs.
// - During calibration capacity, voltage, temperature update; current and TTE hold.
// - After reset run quick calibration; first full one waits at least 40 s.
// - Quick calibration discards a 1.28 s sample, then keeps a second one.
// - Control bit 0 set within first 1.28 s adopts the first sample.
// - Stored external offset is subtracted along with the internal offset.
// - Samples with magnitude below the deadband threshold are discarded.
// - Deadband threshold counts are 4.9 uV each.
// - Deadband threshold zero disables the filter.
// - Remaining capacity counts in units of 3.57 uVh.
// - Time-to-empty in minutes for standby, peak, actual and at-rate loads.
// - Cell voltage is offset corrected and compared with end-of-discharge thresholds.
// - At end-of-discharge thresholds capacity is capped at 6.25 percent or forced to empty.
// - Temperature adjusts compensated capacity and self-discharge loss.
// - Communication lines held low read as zero and put the gauge to sleep.
`timescale 1ns/1ps
module ccoc_gauge
  import ccoc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int CAL_PERIOD  = CAL_PER_TICKS,
  parameter int SD_PERIOD   = SD_TICKS
)(
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic signed [SENSE_W-1:0] sense_sample_i,
  input  wire logic signed [SENSE_W-1:0] cal_sample_i,
  input  wire logic signed [SENSE_W-1:0] ext_offset_i,
  input  wire logic [DB_W-1:0]           charge_deadband_threshold_i,
  input  wire logic [CAP_W-1:0]          cap_full_i,
  input  wire logic [VOLT_W-1:0]         cell_voltage_i,
  input  wire logic [REG_W-1:0]          volt_offset_i,
  input  wire logic [VOLT_W-1:0]         end_discharge_threshold1_i,
  input  wire logic [VOLT_W-1:0]         end_discharge_threshold_f_i,
  input  wire logic [TEMP_W-1:0]         temp_i,
  input  wire ccoc_loads_t               loads_i,
  input  wire logic                      comm_low_i,
  input  wire logic [REG_W-1:0]          reg_addr_i,
  input  wire logic [REG_W-1:0]          reg_wdata_i,
  input  wire logic                      reg_wr_i,
  output logic                           offset_cal_active_o,
  output logic signed [SENSE_W-1:0]      cal_offset_o,
  output logic signed [SENSE_W-1:0]      current_o,
  output logic signed [31:0]             charge_integrator_o,
  output logic [CAP_W-1:0]               capacity_o,
  output logic [CAP_W-1:0]               comp_capacity_o,
  output logic [VOLT_W-1:0]              voltage_o,
  output logic [TEMP_W-1:0]              temp_o,
  output logic                           edv1_o,
  output logic                           edvf_o,
  output ccoc_tte_t                      tte_o,
  output logic                           sleep_o,
  output logic [REG_W-1:0]               reg_rdata_o
);

  // ----------------------------------------------------------------
  // Tick divider, sleep detect and control register
  // ----------------------------------------------------------------
  logic [31:0]      tick_cnt_r, tick_cnt_nxt;
  logic             tick;
  logic [3:0]       low_cnt_r, low_cnt_nxt;
  logic             sleep_r, sleep_nxt;
  logic [REG_W-1:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;

  always_comb
  begin
    tick         = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    low_cnt_nxt  = low_cnt_r;
    sleep_nxt    = sleep_r;
    if (!comm_low_i)
    begin
      low_cnt_nxt = '0;
      sleep_nxt   = 1'b0;
    end
    else if (tick && low_cnt_r != 4'(SLEEP_TICKS))
      low_cnt_nxt = low_cnt_r + 1'b1;
    else if (low_cnt_r == 4'(SLEEP_TICKS))
      sleep_nxt = 1'b1;
    // The comm_low_i gate blocks writes, so no host write can land while the lines idle low.
    ctrl_nxt = ctrl_r;
    if (reg_wr_i && !comm_low_i && reg_addr_i == CTRL_ADDR)
      ctrl_nxt = reg_wdata_i;
    rdata_nxt = (reg_addr_i == CTRL_ADDR && !comm_low_i) ? ctrl_r : '0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_r <= '0;
      low_cnt_r  <= '0;
      sleep_r    <= 1'b0;
      ctrl_r     <= CTRL_RST;
      rdata_r    <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      low_cnt_r  <= low_cnt_nxt;
      sleep_r    <= sleep_nxt;
      ctrl_r     <= ctrl_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Offset calibration sequencer
  // ----------------------------------------------------------------
  ccoc_cal_t                 state_r, state_nxt;
  logic [12:0]               cnt_r, cnt_nxt;
  logic                      first_r, first_nxt;
  logic signed [25:0]        cal_sum_r, cal_sum_nxt, cal_acc;
  logic signed [SENSE_W-1:0] offset_r, offset_nxt;
  logic                      active_r;

  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    first_nxt   = first_r;
    cal_sum_nxt = cal_sum_r;
    offset_nxt  = offset_r;
    cal_acc     = cal_sum_r + 26'(cal_sample_i);
    if (tick)
    begin
      cnt_nxt     = cnt_r + 1'b1;
      cal_sum_nxt = cal_acc;
      case (state_r)
        CAL_SETTLE:
          if (cnt_r == 13'(QUICK_TICKS - 1))
          begin
            cnt_nxt     = '0;
            cal_sum_nxt = '0;
            if (ctrl_r[CTRL_QUICK])
            begin
              offset_nxt = SENSE_W'(cal_acc >>> QUICK_SHIFT);
              state_nxt  = CAL_IDLE;
            end
            else
              state_nxt = CAL_QUICK;
          end
        CAL_QUICK:
          if (cnt_r == 13'(QUICK_TICKS - 1))
          begin
            offset_nxt  = SENSE_W'(cal_acc >>> QUICK_SHIFT);
            state_nxt   = CAL_IDLE;
            cnt_nxt     = '0;
            cal_sum_nxt = '0;
          end
        CAL_IDLE:
        begin
          cal_sum_nxt = '0;
          if (cnt_r == (first_r ? 13'(FULL_DLY_TICKS - 1) : 13'(CAL_PERIOD - 1)))
          begin
            state_nxt = CAL_FULL;
            cnt_nxt   = '0;
          end
        end
        CAL_FULL:
          if (cnt_r == 13'(AVG_TICKS - 1))
          begin
            offset_nxt  = SENSE_W'(cal_acc >>> AVG_SHIFT);
            state_nxt   = CAL_IDLE;
            first_nxt   = 1'b0;
            cnt_nxt     = '0;
            cal_sum_nxt = '0;
          end
        default:
          state_nxt = CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= CAL_SETTLE;
      cnt_r     <= '0;
      first_r   <= 1'b1;
      cal_sum_r <= '0;
      offset_r  <= '0;
      active_r  <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      first_r   <= first_nxt;
      cal_sum_r <= cal_sum_nxt;
      offset_r  <= offset_nxt;
      active_r  <= (state_nxt != CAL_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Integration, capacity, voltage and temperature
  // ----------------------------------------------------------------
  logic signed [SENSE_W+1:0] corr, filt;
  logic [SENSE_W+1:0]        mag;
  logic [31:0]               db_thr;
  logic                      keep, win_end;
  logic signed [31:0]        acc_r, acc_nxt, frac_r, frac_nxt;
  logic signed [25:0]        win_r, win_nxt, win_fin;
  logic [8:0]                wcnt_r, wcnt_nxt;
  logic [19:0]               sd_r, sd_nxt;
  logic signed [SENSE_W-1:0] cur_r, cur_nxt;
  logic [CAP_W-1:0]          cap_r, cap_nxt, comp_r, comp_nxt, floor16;
  logic [VOLT_W-1:0]         volt_r, volt_nxt;
  logic [TEMP_W-1:0]         temp_r, temp_nxt;
  logic                      e1_r, e1_nxt, ef_r, ef_nxt;

  always_comb
  begin
    corr = (SENSE_W+2)'(sense_sample_i) - (SENSE_W+2)'(offset_r)
         - (SENSE_W+2)'(ext_offset_i);
    mag    = corr[SENSE_W+1] ? (SENSE_W+2)'(0) - corr : corr;
    db_thr = 32'(32'(charge_deadband_threshold_i) * DEADBAND_STEP_NV / SENSE_LSB_NV);
    keep   = (charge_deadband_threshold_i == '0) ? (corr != '0)
           : (32'(mag) >= db_thr);
    filt   = keep ? corr : '0;
    win_fin = win_r + 26'(corr);
    win_end = tick && (wcnt_r == 9'(AVG_TICKS - 1));
    floor16 = cap_full_i >> EDV1_SHIFT;
    acc_nxt = acc_r;
    frac_nxt = frac_r;
    win_nxt = win_r;
    wcnt_nxt = wcnt_r;
    sd_nxt  = sd_r;
    cur_nxt = cur_r;
    cap_nxt = cap_r;
    comp_nxt = comp_r;
    volt_nxt = volt_r;
    temp_nxt = temp_r;
    e1_nxt  = e1_r;
    ef_nxt  = ef_r;
    if (tick)
    begin
      acc_nxt  = acc_r + 32'(filt);
      frac_nxt = frac_r + 32'(filt);
      if (frac_nxt >= CAP_UNIT_CNT)
      begin
        frac_nxt = frac_nxt - CAP_UNIT_CNT;
        if (cap_nxt < cap_full_i)
          cap_nxt = cap_nxt + 1'b1;
      end
      else if (frac_nxt <= -CAP_UNIT_CNT)
      begin
        frac_nxt = frac_nxt + CAP_UNIT_CNT;
        if (cap_nxt != '0)
          cap_nxt = cap_nxt - 1'b1;
      end
      sd_nxt = (sd_r == 20'(SD_PERIOD - 1)) ? '0 : sd_r + 1'b1;
      if (sd_r == 20'(SD_PERIOD - 1))
        cap_nxt = cap_nxt - (cap_nxt >> ((temp_i >= TEMP_HOT) ? SD_HOT_SHIFT : SD_SHIFT));
      volt_nxt = cell_voltage_i - VOLT_W'(volt_offset_i);
      e1_nxt   = (volt_nxt <= end_discharge_threshold1_i);
      ef_nxt   = (volt_nxt <= end_discharge_threshold_f_i);
      if (ef_nxt)
        cap_nxt = '0;
      else if (e1_nxt && cap_nxt > floor16)
        cap_nxt = floor16;
      temp_nxt = temp_i;
      comp_nxt = (temp_i <= TEMP_COLD) ? cap_nxt - (cap_nxt >> COLD_SHIFT) : cap_nxt;
      wcnt_nxt = win_end ? '0 : wcnt_r + 1'b1;
      win_nxt  = win_end ? '0 : win_fin;
      // The window keeps running through calibration; only its result is dropped.
      if (win_end && state_r == CAL_IDLE)
        cur_nxt = SENSE_W'(win_fin >>> AVG_SHIFT);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      acc_r  <= '0;
      frac_r <= '0;
      win_r  <= '0;
      wcnt_r <= '0;
      sd_r   <= '0;
      cur_r  <= '0;
      cap_r  <= '0;
      comp_r <= '0;
      volt_r <= '0;
      temp_r <= '0;
      e1_r   <= 1'b0;
      ef_r   <= 1'b0;
    end
    else
    begin
      acc_r  <= acc_nxt;
      frac_r <= frac_nxt;
      win_r  <= win_nxt;
      wcnt_r <= wcnt_nxt;
      sd_r   <= sd_nxt;
      cur_r  <= cur_nxt;
      cap_r  <= cap_nxt;
      comp_r <= comp_nxt;
      volt_r <= volt_nxt;
      temp_r <= temp_nxt;
      e1_r   <= e1_nxt;
      ef_r   <= ef_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Time-to-empty sequencer
  // ----------------------------------------------------------------
  logic                      busy_r, busy_nxt, start_r, start_nxt, dv_done;
  logic [1:0]                idx_r, idx_nxt;
  logic signed [SENSE_W-1:0] load;
  logic [SENSE_W:0]          lmag;
  logic [DEN_W-1:0]          den;
  logic [NUM_W-1:0]          num, quo;
  logic [CAP_W-1:0]          qsat;
  ccoc_tte_t                 tte_r, tte_nxt;

  always_comb
  begin
    case (idx_r)
      2'd0:    load = loads_i.standby;
      2'd1:    load = loads_i.peak;
      2'd2:    load = cur_r;
      default: load = loads_i.at_rate;
    endcase
    lmag = (SENSE_W+1)'(0) - (SENSE_W+1)'(load);
    // Charge or zero load leaves the divisor at zero: result saturates.
    den  = load[SENSE_W-1] ? DEN_W'(32'(lmag) * TTE_DEN_K) : '0;
    num  = NUM_W'(32'(cap_r) * TTE_NUM_K);
    qsat = (|quo[NUM_W-1:CAP_W]) ? '1 : quo[CAP_W-1:0];
    busy_nxt  = busy_r;
    idx_nxt   = idx_r;
    start_nxt = 1'b0;
    tte_nxt   = tte_r;
    if (!busy_r && win_end && state_r == CAL_IDLE)
    begin
      busy_nxt  = 1'b1;
      idx_nxt   = '0;
      start_nxt = 1'b1;
    end
    else if (busy_r && dv_done)
    begin
      case (idx_r)
        2'd0:    tte_nxt.standby = qsat;
        2'd1:    tte_nxt.peak    = qsat;
        2'd2:    tte_nxt.actual  = qsat;
        default: tte_nxt.at_rate = qsat;
      endcase
      if (idx_r == 2'd3)
        busy_nxt = 1'b0;
      else
      begin
        idx_nxt   = idx_r + 1'b1;
        start_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      busy_r  <= 1'b0;
      idx_r   <= '0;
      start_r <= 1'b0;
      tte_r   <= '1;
    end
    else
    begin
      busy_r  <= busy_nxt;
      idx_r   <= idx_nxt;
      start_r <= start_nxt;
      tte_r   <= tte_nxt;
    end
  end

  ccoc_div u_div (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start_r),
    .num_i     (num),
    .den_i     (den),
    .done_o    (dv_done),
    .quo_o     (quo)
  );

  assign offset_cal_active_o = active_r;
  assign cal_offset_o        = offset_r;
  assign current_o           = cur_r;
  assign charge_integrator_o = acc_r;
  assign capacity_o          = cap_r;
  assign comp_capacity_o     = comp_r;
  assign voltage_o           = volt_r;
  assign temp_o              = temp_r;
  assign edv1_o              = e1_r;
  assign edvf_o              = ef_r;
  assign tte_o               = tte_r;
  assign sleep_o             = sleep_r;
  assign reg_rdata_o         = rdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [12:0] since_rst_r;
  always_ff @(posedge sys_clk_i)
    if (!rst_n_i)
      since_rst_r <= '0;
    else if (tick && since_rst_r != 13'(FULL_DLY_TICKS))
      since_rst_r <= since_rst_r + 1'b1;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence settle_end_s;
    state_r == CAL_SETTLE && tick && cnt_r == 13'(QUICK_TICKS - 1);
  endsequence

  integ_step_a: assert property (tick |=> acc_r == $past(acc_r) + 32'($past(filt)))
    else $error("integrator missed a sample");
  deadband_hold_a: assert property (tick && charge_deadband_threshold_i != '0 && 32'(mag) < db_thr
    |=> $stable(charge_integrator_o)) else $error("sub-threshold sample counted");
  cur_hold_a: assert property (state_r != CAL_IDLE |=> $stable(current_o))
    else $error("current changed during calibration");
  cal_flag_a: assert property ($rose(state_r == CAL_FULL) |-> offset_cal_active_o ##1 offset_cal_active_o)
    else $error("calibration flag low during calibration");
  full_delay_a: assert property (state_r == CAL_FULL |-> since_rst_r == 13'(FULL_DLY_TICKS))
    else $error("full calibration too early");
  quick_two_a: assert property (settle_end_s and !ctrl_r[CTRL_QUICK] |=> state_r == CAL_QUICK)
    else $error("settling sample not discarded");
  quick_skip_a: assert property (settle_end_s and ctrl_r[CTRL_QUICK] |=> state_r == CAL_IDLE && !offset_cal_active_o)
    else $error("first sample not adopted");
  edv_empty_a: assert property (edvf_o |-> capacity_o == '0)
    else $error("capacity not empty at final threshold");
  wake_a: assert property (!comm_low_i |=> !sleep_o)
    else $error("sleep with active lines");

endmodule

// ===== verif/ccoc_host.sv
`timescale 1ns/1ps
module ccoc_host
  import ccoc_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             wr_req_i,
  input  wire logic [REG_W-1:0] wr_data_i,
  input  wire logic             idle_lines_i,
  output logic [REG_W-1:0]      reg_addr_o  = 8'h00,
  output logic [REG_W-1:0]      reg_wdata_o = 8'h00,
  output logic                  reg_wr_o    = 1'b0,
  output logic                  comm_low_o  = 1'b0
);
  // The data byte inverts every cycle between writes, so the last written value recurs every other cycle.
  always_ff @(posedge sys_clk_i)
  begin
    reg_addr_o  <= CTRL_ADDR;
    reg_wdata_o <= wr_req_i ? wr_data_i : ~reg_wdata_o;
    reg_wr_o    <= wr_req_i & ~idle_lines_i;
    comm_low_o  <= idle_lines_i;
  end
endmodule

// ===== verif/ccoc_gauge_test.sv
`timescale 1ns/1ps
module ccoc_gauge_test;
  import ccoc_pkg::*;
  localparam int TC = 4;
  logic                      sys_clk_i = 1'b0;
  logic                      rst_n_i   = 1'b0;
  logic signed [SENSE_W-1:0] sense_r   = '0;
  logic signed [SENSE_W-1:0] cal_r     = 16'sh0005;
  logic signed [SENSE_W-1:0] ext_r     = '0;
  logic [DB_W-1:0]           db_r      = '0;
  logic [VOLT_W-1:0]         volt_r    = 16'h1000;
  logic [CAP_W-1:0]          cap_full_r = 16'h0040;
  logic [REG_W-1:0]          voff_r    = 8'h00;
  logic [VOLT_W-1:0]         edv1_thr_r = 16'h0800;
  logic [TEMP_W-1:0]         temp_r    = 12'h4a0;
  ccoc_loads_t               loads_r   = '0;
  logic                      wr_req    = 1'b0;
  logic                      low_r     = 1'b0;
  logic [REG_W-1:0]          addr, wdata, rdata;
  logic                      wr, comm_low, cal_act, edvf, slp;
  logic signed [SENSE_W-1:0] cal_off, cur;
  logic signed [31:0]        integ;
  logic [CAP_W-1:0]          cap, comp;
  logic [VOLT_W-1:0]         volt_seen;
  logic [TEMP_W-1:0]         temp_seen;
  logic                      edv1;
  ccoc_tte_t                 tte;
  int                        error_cnt = 0;
  int                        samples_checked = 0;
  int                        cyc = 0;
  int                        n;
  int                        mark;

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) cyc <= cyc + 1;

  ccoc_host i_host (.sys_clk_i(sys_clk_i), .wr_req_i(wr_req), .wr_data_i(8'h01), .idle_lines_i(low_r),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .comm_low_o(comm_low));

  ccoc_gauge #(.TICK_CYCLES(TC), .CAL_PERIOD(600), .SD_PERIOD(1000)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sense_sample_i(sense_r), .cal_sample_i(cal_r),
    .ext_offset_i(ext_r), .charge_deadband_threshold_i(db_r), .cap_full_i(cap_full_r),
    .cell_voltage_i(volt_r), .volt_offset_i(voff_r), .end_discharge_threshold1_i(edv1_thr_r),
    .end_discharge_threshold_f_i(16'h0400), .temp_i(temp_r), .loads_i(loads_r), .comm_low_i(comm_low),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .offset_cal_active_o(cal_act),
    .cal_offset_o(cal_off), .current_o(cur), .charge_integrator_o(integ), .capacity_o(cap),
    .comp_capacity_o(comp), .voltage_o(volt_seen), .temp_o(temp_seen), .edv1_o(edv1), .edvf_o(edvf),
    .tte_o(tte), .sleep_o(slp), .reg_rdata_o(rdata));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sampling on the falling edge keeps reads clear of the design's own updates.
  task automatic ticks(input int k);
    repeat (k * TC) @(negedge sys_clk_i);
  endtask

  task automatic wait_cal(input logic lvl);
    n = 0;
    while (cal_act !== lvl && n < 20000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("cal_level", cal_act, lvl);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wr_req  <= 1'b1;
    @(posedge sys_clk_i);
    wr_req <= 1'b0;
    @(negedge sys_clk_i);
    chk("cal_active_rst", cal_act, 1);
    chk("tte_rst", tte.standby, 16'hffff);
    wait_cal(1'b0);
    chk("quick_len", n > 128 * TC - 8 && n < 128 * TC + 8, 1);
    chk("quick_offset", cal_off, 16'h0005);
    chk("ctrl_read", rdata, 8'h01);
    $display("test quick calibration done");
    @(posedge sys_clk_i);
    sense_r <= 16'sh006b;
    ext_r   <= 16'sh0002;
    ticks(1025);
    chk("current_mean", cur, 16'h0064);
    $display("test current done");
    @(posedge sys_clk_i);
    db_r <= 8'h65;
    ticks(2);
    mark = integ;
    ticks(20);
    chk("deadband_hold", integ - mark, 0);
    @(posedge sys_clk_i);
    db_r <= 8'h00;
    ticks(2);
    mark = integ;
    ticks(20);
    chk("integrate_up", integ - mark, 2000);
    @(posedge sys_clk_i);
    sense_r <= 16'shffa3;
    ticks(2);
    mark = integ;
    ticks(20);
    chk("integrate_down", integ - mark, -32'sd2000);
    $display("test deadband done");
    wait_cal(1'b1);
    chk("full_delay", cyc >= 4000 * TC, 1);
    wait_cal(1'b0);
    chk("full_len", n > 508 * TC && n < 516 * TC, 1);
    $display("test full calibration done");
    @(posedge sys_clk_i);
    sense_r <= 16'sh7fff;
    temp_r  <= TEMP_COLD;
    voff_r  <= 8'h10;
    ticks(80);
    // The unit remainder left by earlier scenarios is unknown, so one unit either way is accepted.
    chk("cap_up", cap >= 16'd8 && cap <= 16'd10, 1);
    chk("comp_cold", comp, cap - 16'd1);
    chk("temp_track", temp_seen, TEMP_COLD);
    chk("volt_corr", volt_seen, 16'h0ff0);
    chk("edv1_off", edv1, 0);
    @(posedge sys_clk_i);
    volt_r <= 16'h0700;
    ticks(2);
    chk("edv1_on", edv1, 1);
    chk("cap_floor", cap, 16'h0004);
    @(posedge sys_clk_i);
    volt_r <= 16'h0100;
    ticks(4);
    chk("edv_final", edvf, 1);
    chk("cap_empty", cap, 0);
    @(posedge sys_clk_i);
    low_r <= 1'b1;
    ticks(4);
    chk("sleep_on", slp, 1);
    chk("rdata_low", rdata, 8'h00);
    @(posedge sys_clk_i);
    low_r <= 1'b0;
    ticks(1);
    chk("sleep_off", slp, 0);
    $display("test edv and sleep done");
    // A second reset without the shortcut bit must run both quick samples.
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    cal_r   <= 16'sh0040;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("rst_integ", integ, 0);
    chk("rst_ctrl", rdata, 8'h00);
    // Tick 127 ends the settling sample; the new value reaches only the kept one.
    repeat (513) @(posedge sys_clk_i);
    cal_r <= 16'sh0009;
    wait_cal(1'b0);
    chk("slow_len", n > 500 && n < 520, 1);
    chk("slow_offset", cal_off, 16'h0009);
    $display("test slow quick calibration done");
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    error_cnt++;
    close_out();
  end
endmodule
